// ### rtl/sbdm_pkg.sv
// Constants and carrier types of the serial buffer DMA mover.
package sbdm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CS   = 8'hdc;
	localparam logic [7:0] ADDR_LOW  = 8'hdd;
	localparam logic [7:0] ADDR_HIGH = 8'hde;
	localparam logic [7:0] ADDR_CNT  = 8'hdf;

	// ----------------------------------------
	// Control and status bit positions
	// ----------------------------------------
	localparam int CS_RUN = 0;
	localparam int CS_DIR = 1;
	localparam int CS_ERR = 2;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [13:0] BASE_RST  = 14'h0100;
	localparam logic [4:0]  CNT_RST   = 5'h00;
	localparam logic [13:0] RAM_LO    = 14'h0100;
	localparam logic [13:0] RAM_HI    = 14'h10ff;
	localparam logic [4:0]  BUF_BYTES = 5'h10;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_XFER = 1'b1
	} sbdm_st_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} sbdm_io_req_t;

	typedef struct packed {
		logic [13:0] ram_addr;
		logic        ram_re;
		logic        ram_we;
		logic [7:0]  ram_wdata;
		logic        buf_sel;
		logic [3:0]  buf_idx;
		logic        buf_re;
		logic        buf_we;
		logic [7:0]  buf_wdata;
	} sbdm_mem_req_t;

	typedef struct packed {
		sbdm_st_t      st;
		logic [13:0]   base;
		logic [4:0]    len;
		logic          dir;
		logic          err;
		logic          run;
		logic          sel;
		logic [4:0]    pos;
		logic          rpend;
		logic [4:0]    rpos;
		sbdm_mem_req_t req;
		logic          halt;
		logic          irq;
		logic          sec_irq;
		logic [7:0]    rdata;
	} sbdm_state_t;

endpackage

// ### rtl/sbdm_mover.sv
// CPU-stalling DMA mover between system RAM and the serial port buffers.
//
// Behaviour
// - A good launch clears the error flag.
// - A launch with bad base, bad end or count over 16 sets the error flag.
// - Software writing zero to the error bit outside a bad launch clears it.
// - Error flag with serial interrupts enabled raises the serial interrupt.
// - Direction one copies RAM into the empty transmit buffer.
// - Direction zero copies the older receive buffer into RAM.
// - Software sets the run bit to start; hardware clears it at the end.
// - The processor is halted while the run bit is set.
// - A running transfer cannot be interrupted or altered.
// - A 14-bit base address spans two byte registers.
// - The base address resets to 0x0100.
// - The whole transfer must lie in 0x0100..0x10ff or nothing moves.
// - A range failure raises the security interrupt unless masked.
// - A range failure leaves address and count registers unchanged.
// - After a transfer the base becomes last address plus one.
// - The byte count register keeps its value after a transfer.
// - Reserved bits of address-high and count registers read zero.
// - Active only in buffer mode; registers dead while the port is off.
// - N bytes take N+1 processor cycles.
`timescale 1ns/1ps

module sbdm_mover (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// Processor register port
	input  wire sbdm_pkg::sbdm_io_req_t io_req,
	output logic [7:0]                  io_rdata,
	output logic                        cpu_halt,
	// Serial port status
	input  wire logic                   port_enable,
	input  wire logic                   dual_port_buffer_mode,
	input  wire logic                   tx_free_sel,
	input  wire logic                   rx_oldest_sel,
	input  wire logic                   serial_irq_en,
	input  wire logic                   sec_irq_mask,
	// Memory side
	output sbdm_pkg::sbdm_mem_req_t     mem_req,
	input  wire logic [7:0]             ram_rdata,
	input  wire logic [7:0]             buf_rdata,
	// Interrupts
	output logic                        serial_irq,
	output logic                        sec_irq
);

	// ----------------------------------------
	// Range check
	// ----------------------------------------
	function automatic logic range_ok(input logic [13:0] b, input logic [4:0] l);
		logic [14:0] last;
		last = 15'({1'b0, b} + {10'h000, l}) - 15'(l != 5'h00);
		return (l <= sbdm_pkg::BUF_BYTES) && (b >= sbdm_pkg::RAM_LO) &&
			(b <= sbdm_pkg::RAM_HI) && (last <= {1'b0, sbdm_pkg::RAM_HI});
	endfunction

	sbdm_pkg::sbdm_state_t q;
	sbdm_pkg::sbdm_state_t n;
	logic                  acc;
	logic                  wr_ok;
	logic                  launch;
	logic                  go_ok;
	logic                  go_bad;
	logic                  drained;
	logic                  cs_wr;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	always_comb begin
		acc = port_enable;
		wr_ok = acc && io_req.we && (q.st == sbdm_pkg::ST_IDLE);
		cs_wr = wr_ok && (io_req.addr == sbdm_pkg::ADDR_CS);
		drained = !q.rpend && !q.req.ram_we && !q.req.buf_we;
		launch = cs_wr && io_req.wdata[sbdm_pkg::CS_RUN] && dual_port_buffer_mode && drained;
		go_ok = launch && range_ok(q.base, q.len);
		go_bad = launch && !range_ok(q.base, q.len);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		n.req.ram_re = 1'b0;
		n.req.ram_we = 1'b0;
		n.req.buf_re = 1'b0;
		n.req.buf_we = 1'b0;
		n.rpend = 1'b0;
		n.sec_irq = 1'b0;
		n.rdata = 8'h00;
		if (acc && io_req.re) begin
			case (io_req.addr)
				sbdm_pkg::ADDR_CS: begin
					n.rdata = {5'h00, q.err, q.dir, q.run};
				end
				sbdm_pkg::ADDR_LOW: begin
					n.rdata = q.base[7:0];
				end
				sbdm_pkg::ADDR_HIGH: begin
					n.rdata = {2'b00, q.base[13:8]};
				end
				sbdm_pkg::ADDR_CNT: begin
					n.rdata = {3'b000, q.len};
				end
				default: begin
					n.rdata = 8'h00;
				end
			endcase
		end
		if (wr_ok) begin
			case (io_req.addr)
				sbdm_pkg::ADDR_LOW: begin
					n.base[7:0] = io_req.wdata;
				end
				sbdm_pkg::ADDR_HIGH: begin
					n.base[13:8] = io_req.wdata[5:0];
				end
				sbdm_pkg::ADDR_CNT: begin
					n.len = io_req.wdata[4:0];
				end
				sbdm_pkg::ADDR_CS: begin
					n.dir = io_req.wdata[sbdm_pkg::CS_DIR];
					if (!io_req.wdata[sbdm_pkg::CS_ERR]) begin
						n.err = 1'b0;
					end
				end
				default: begin
					n.dir = q.dir;
				end
			endcase
		end
		if (go_bad) begin
			n.err = 1'b1;
			n.sec_irq = !sec_irq_mask;
		end
		if (go_ok) begin
			n.err = 1'b0;
			n.dir = io_req.wdata[sbdm_pkg::CS_DIR];
			n.sel = io_req.wdata[sbdm_pkg::CS_DIR] ? tx_free_sel : rx_oldest_sel;
			n.st = sbdm_pkg::ST_XFER;
			n.run = 1'b1;
			n.halt = 1'b1;
			n.pos = 5'h00;
		end
		if (q.st == sbdm_pkg::ST_XFER) begin
			if (q.pos < q.len) begin
				n.rpend = 1'b1;
				n.rpos = q.pos;
				n.pos = 5'(q.pos + 5'h01);
				n.req.buf_sel = q.sel;
				if (q.dir) begin
					n.req.ram_re = 1'b1;
					n.req.ram_addr = 14'(q.base + {9'h000, q.pos});
				end else begin
					n.req.buf_re = 1'b1;
					n.req.buf_idx = q.pos[3:0];
				end
			end else begin
				n.st = sbdm_pkg::ST_IDLE;
				n.run = 1'b0;
				n.halt = 1'b0;
				n.base = 14'(q.base + {9'h000, q.len});
			end
		end
		if (q.rpend) begin
			if (q.dir) begin
				n.req.buf_we = 1'b1;
				n.req.buf_idx = q.rpos[3:0];
				n.req.buf_wdata = ram_rdata;
			end else begin
				n.req.ram_we = 1'b1;
				n.req.ram_addr = 14'(q.base + {9'h000, q.rpos});
				n.req.ram_wdata = buf_rdata;
			end
		end
		n.irq = q.err && serial_irq_en;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			q <= '0;
			q.st <= sbdm_pkg::ST_IDLE;
			q.base <= sbdm_pkg::BASE_RST;
			q.len <= sbdm_pkg::CNT_RST;
		end else begin
			q <= n;
		end
	end

	assign io_rdata = q.rdata;
	assign cpu_halt = q.halt;
	assign mem_req = q.req;
	assign serial_irq = q.irq;
	assign sec_irq = q.sec_irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [5:0] halt_cycles;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			halt_cycles <= 6'h00;
		end else if (q.halt) begin
			halt_cycles <= 6'(halt_cycles + 6'h01);
		end else begin
			halt_cycles <= 6'h00;
		end
	end

	good_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
		go_ok |=> !q.err && q.halt)
		else $error("Good launch did not clear the error flag.");

	bad_set_a: assert property (@(posedge clk_sys) disable iff (srst)
		go_bad |=> q.err && !q.halt && !q.run)
		else $error("Bad launch did not set the error flag.");

	sw_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
		cs_wr && !io_req.wdata[sbdm_pkg::CS_ERR] && !go_bad |=> !q.err)
		else $error("Software clear of the error flag failed.");

	irq_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
		q.err && serial_irq_en |=> serial_irq)
		else $error("Serial interrupt missing while error flag set.");

	tx_dest_a: assert property (@(posedge clk_sys) disable iff (srst)
		mem_req.buf_we |-> q.dir && mem_req.buf_sel == q.sel)
		else $error("Buffer written outside transmit direction.");

	rx_dest_a: assert property (@(posedge clk_sys) disable iff (srst)
		mem_req.ram_we |-> !q.dir)
		else $error("RAM written outside receive direction.");

	run_end_a: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(q.halt) |-> !q.run && q.st == sbdm_pkg::ST_IDLE)
		else $error("Run bit not cleared at transfer end.");

	xfer_lock_a: assert property (@(posedge clk_sys) disable iff (srst)
		q.st == sbdm_pkg::ST_XFER && io_req.we |=> $stable(q.len) && $stable(q.dir))
		else $error("Register write altered a running transfer.");

	sec_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
		go_bad && !sec_irq_mask |=> sec_irq ##1 !sec_irq)
		else $error("Security interrupt not pulsed on range failure.");

	keep_regs_a: assert property (@(posedge clk_sys) disable iff (srst)
		go_bad |=> $stable(q.base) && $stable(q.len))
		else $error("Registers changed on range failure.");

	chain_base_a: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(q.run) |-> q.base == 14'($past(q.base) + {9'h000, q.len}))
		else $error("Base address not advanced past the transfer.");

	cycle_cnt_a: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(q.halt) |-> halt_cycles == 6'({1'b0, q.len} + 6'h01))
		else $error("Transfer did not take count plus one cycles.");

endmodule

// ### testbench/sbdm_mem_model.sv
// Behavioural RAM and serial buffer model at the far side of the mover.
`timescale 1ns/1ps

module sbdm_mem_model (
	// Clock
	input  wire logic                    clk_sys,
	// Mover requests and read data
	input  wire sbdm_pkg::sbdm_mem_req_t mem_req,
	output logic [7:0]                   ram_rdata,
	output logic [7:0]                   buf_rdata
);
	logic [7:0] ram  [0:16383];
	logic [7:0] bufm [0:31];

	initial begin
		for (int i = 0; i < 16384; i++) ram[i] = i[7:0] ^ 8'h5a;
		for (int i = 0; i < 32; i++) bufm[i] = 8'hc0 + i[7:0];
	end

	// Reads answer from the registered address while the strobe stands; otherwise the inverse shows.
	assign ram_rdata = mem_req.ram_re ? ram[mem_req.ram_addr] : ~ram[mem_req.ram_addr];
	assign buf_rdata = mem_req.buf_re ? bufm[{mem_req.buf_sel, mem_req.buf_idx}] :
		~bufm[{mem_req.buf_sel, mem_req.buf_idx}];

	always_ff @(posedge clk_sys) begin
		if (mem_req.ram_we) ram[mem_req.ram_addr] <= mem_req.ram_wdata;
		if (mem_req.buf_we) bufm[{mem_req.buf_sel, mem_req.buf_idx}] <= mem_req.buf_wdata;
	end
endmodule

// ### testbench/serial_buffer_dma_mover_test.sv
// Self-checking bench of the serial buffer DMA mover.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end

module serial_buffer_dma_mover_test;
	logic clk_sys, srst, port_enable, dual_port_buffer_mode, tx_free_sel, rx_oldest_sel, serial_irq_en, sec_irq_mask;
	sbdm_pkg::sbdm_io_req_t  io_req;
	sbdm_pkg::sbdm_mem_req_t mem_req;
	logic [7:0] io_rdata, ram_rdata, buf_rdata;
	logic       cpu_halt, serial_irq, sec_irq;
	int         miscompares, checks_done, h, s;
	logic [7:0] rows [4][3] = '{'{8'hdd, 8'h34, 8'h34}, '{8'hde, 8'hff, 8'h3f},
		'{8'hdf, 8'hff, 8'h1f}, '{8'he0, 8'h55, 8'h00}};
	logic [7:0] errs [3][3] = '{'{8'h10, 8'hf8, 8'h10}, '{8'h01, 8'h00, 8'h11}, '{8'h00, 8'hff, 8'h01}};

	sbdm_mover dut_u (.clk_sys(clk_sys), .srst(srst), .io_req(io_req), .io_rdata(io_rdata),
		.cpu_halt(cpu_halt), .port_enable(port_enable), .dual_port_buffer_mode(dual_port_buffer_mode),
		.tx_free_sel(tx_free_sel), .rx_oldest_sel(rx_oldest_sel), .serial_irq_en(serial_irq_en),
		.sec_irq_mask(sec_irq_mask), .mem_req(mem_req), .ram_rdata(ram_rdata),
		.buf_rdata(buf_rdata), .serial_irq(serial_irq), .sec_irq(sec_irq));
	sbdm_mem_model mem_u (.clk_sys(clk_sys), .mem_req(mem_req), .ram_rdata(ram_rdata), .buf_rdata(buf_rdata));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys) io_req = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(negedge clk_sys) io_req.we = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys) io_req = '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(negedge clk_sys) io_req.re = 1'b0;
		`CHK(io_rdata, e)
	endtask

	// Launches with the given control byte and counts halt and security pulse cycles.
	task automatic launch(input logic [7:0] d);
		wr(8'hdc, d);
		h = 0;
		s = 0;
		repeat (30) begin
			if (cpu_halt === 1'b1) h++;
			if (sec_irq === 1'b1) s++;
			@(negedge clk_sys);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#100us;
		miscompares++;
		report_and_stop();
	end

	initial begin
		{port_enable, dual_port_buffer_mode, tx_free_sel, serial_irq_en} = 4'hf;
		{srst, rx_oldest_sel, sec_irq_mask} = 3'b100;
		io_req = '0;
		miscompares = 0;
		checks_done = 0;
		repeat (10) @(negedge clk_sys);
		srst = 1'b0;
		foreach (rows[i]) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2]);
		end
		$display("test register rows done");
		srst = 1'b1;
		@(negedge clk_sys) srst = 1'b0;
		rd(8'hdd, 8'h00);
		rd(8'hde, 8'h01);
		rd(8'hdf, 8'h00);
		rd(8'hdc, 8'h00);
		$display("test reset values done");
		wr(8'hdd, 8'h10);
		wr(8'hdf, 8'h03);
		launch(8'h03);
		`CHK(h, 4)
		for (int k = 0; k < 3; k++) `CHK(mem_u.bufm[16 + k], mem_u.ram[16'h0110 + k])
		rd(8'hdc, 8'h02);
		rd(8'hdd, 8'h13);
		rd(8'hdf, 8'h03);
		wr(8'hdf, 8'h02);
		launch(8'h01);
		`CHK(h, 3)
		for (int k = 0; k < 2; k++) `CHK(mem_u.ram[16'h0113 + k], mem_u.bufm[k])
		rd(8'hdd, 8'h15);
		$display("test transfers done");
		foreach (errs[i]) begin
			wr(8'hde, errs[i][0]);
			wr(8'hdd, errs[i][1]);
			wr(8'hdf, errs[i][2]);
			launch(8'h03);
			`CHK(h, 0)
			`CHK(s, 1)
			`CHK(serial_irq, 1'b1)
			rd(8'hdc, 8'h06);
			rd(8'hdd, errs[i][1]);
			rd(8'hdf, errs[i][2]);
		end
		wr(8'hdc, 8'h02);
		rd(8'hdc, 8'h02);
		`CHK(serial_irq, 1'b0)
		sec_irq_mask = 1'b1;
		launch(8'h03);
		`CHK(s, 0)
		serial_irq_en = 1'b0;
		@(negedge clk_sys);
		`CHK(serial_irq, 1'b0)
		serial_irq_en = 1'b1;
		wr(8'hde, 8'h01);
		launch(8'h03);
		rd(8'hdc, 8'h02);
		$display("test errors done");
		wr(8'hdf, 8'h04);
		wr(8'hdc, 8'h03);
		wr(8'hdf, 8'h1f);
		rd(8'hdf, 8'h04);
		dual_port_buffer_mode = 1'b0;
		launch(8'h03);
		`CHK(h, 0)
		port_enable = 1'b0;
		wr(8'hdd, 8'h77);
		rd(8'hdd, 8'h00);
		port_enable = 1'b1;
		rd(8'hdd, 8'h04);
		$display("test port gating done");
		report_and_stop();
	end
endmodule
